// *** trc_thermal_restart.v ***
// Thermal restart control: shutdown, arming, restart reset and wake-up gating
// What this block does
// [R1] Enable bit 3 at 0x1802 powers unit
// [R2] Any reset clears the enable bit
// [R3] Select bit picks low or high threshold
// [R4] Any reset clears the select bit
// [R5] Enabled and threshold reached enters deepest stop
// [R6] Recovery resets core, vector at 0xdffe
// [R7] No restart unless first armed outside range
// [R8] Armed flag readable at bit 0, 0x180f
// [R9] Any reset sets armed flag
// [R10] Armed one: restart on recovery when enabled
// [R11] Armed zero: writes setting enable ignored
// [R12] Arm on rearm crossing, disarm on recovery
// [R13] Shutdown suppresses wake-up interrupt and reset
// [R14] Wake-up counters keep running when suppressed
// [R15] Comparator crossings arrive as synchronised inputs
`timescale 1ns/10ps
`include "trc_defines.vh"
module trc_thermal_restart (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire temp_low_shutdown,
  input wire temp_high_shutdown,
  input wire temp_rearm_cross,
  input wire temp_recovery_cross,
  input wire wake_irq_in,
  input wire wake_rst_in,
  output wire wake_irq_out,
  output wire wake_rst_out,
  output reg stop_req,
  output reg core_rst_req,
  output wire [15:0] rst_vector,
  output wire irq
);

  // ----------------------------------------
  // Comparator inputs
  // ----------------------------------------
  wire [3:0] temp_sync;
  trc_sync3 #(.W(4)) u_sync ( // [R15]
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d_in({temp_recovery_cross, temp_rearm_cross, temp_high_shutdown, temp_low_shutdown}),
    .q_out(temp_sync)
  );
  wire low_hit = temp_sync[0];
  wire high_hit = temp_sync[1];
  wire rearm_hit = temp_sync[2];
  wire recov_hit = temp_sync[3];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg enable_r;
  reg hsel_r;
  reg armed_r;
  reg rearm_d_r;
  reg recov_d_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] pulse_cnt_r;
  reg [`TRC_NUM_EVT-1:0] stat_r;
  reg [`TRC_NUM_EVT-1:0] mask_r;
  wire [`TRC_NUM_EVT-1:0] evt;

  wire wr_opt = reg_wr && (reg_addr == `TRC_ADDR_OPT1);
  wire wr_stat = reg_wr && (reg_addr == `TRC_ADDR_IRQ_STAT);
  wire wr_mask = reg_wr && (reg_addr == `TRC_ADDR_IRQ_MASK);

  // Selected shutdown level for the chosen extreme
  wire shut_hit = hsel_r ? high_hit : low_hit; // [R3]
  wire rearm_rise = rearm_hit && !rearm_d_r;
  wire recov_rise = recov_hit && !recov_d_r;

  // ----------------------------------------
  // Option bits and armed flag
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      enable_r <= 1'b0; // [R2]
      hsel_r <= 1'b0; // [R4]
      armed_r <= `TRC_ARMED_RST; // [R9]
      rearm_d_r <= 1'b0;
      recov_d_r <= 1'b0;
    end else if (ce) begin
      rearm_d_r <= rearm_hit;
      recov_d_r <= recov_hit;
      if (wr_opt) begin
        hsel_r <= reg_wdata[`TRC_BIT_HSEL];
        // Clearing always works; setting needs the armed flag
        if (!reg_wdata[`TRC_BIT_ENABLE] || armed_r) begin // [R11]
          enable_r <= reg_wdata[`TRC_BIT_ENABLE]; // [R1]
        end
      end
      // Arming wins if both crossings land together
      if (rearm_rise) begin
        armed_r <= 1'b1; // [R12]
      end else if (recov_rise) begin
        armed_r <= 1'b0; // [R12]
      end
    end
  end

  // ----------------------------------------
  // Shutdown and restart sequencer
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `TRC_ST_RUN: begin
        if (enable_r && shut_hit) begin
          state_nxt = `TRC_ST_STOP; // [R5]
        end
      end
      `TRC_ST_STOP: begin
        // Only an armed unit may leave stop through a reset
        if (enable_r && armed_r && recov_rise) begin // [R7] [R10]
          state_nxt = `TRC_ST_RESTART; // [R6]
        end else if (!enable_r) begin
          state_nxt = `TRC_ST_RUN;
        end
      end
      `TRC_ST_RESTART: begin
        if (pulse_cnt_r == `TRC_RST_PULSE_CYC) begin
          state_nxt = `TRC_ST_RUN;
        end
      end
      default: begin
        state_nxt = `TRC_ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      state_r <= `TRC_ST_RUN;
      pulse_cnt_r <= 4'h0;
      stop_req <= 1'b0;
      core_rst_req <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      if (state_r == `TRC_ST_RESTART) begin
        pulse_cnt_r <= pulse_cnt_r + 4'h1;
      end else begin
        pulse_cnt_r <= 4'h0;
      end
      stop_req <= (state_nxt == `TRC_ST_STOP); // [R5]
      core_rst_req <= (state_nxt == `TRC_ST_RESTART); // [R6]
    end
  end

  // Core fetches its start address from this vector after restart
  assign rst_vector = `TRC_RST_VECTOR; // [R6]

  // ----------------------------------------
  // Wake-up timer gating
  // ----------------------------------------
  // Only outputs are gated; the timer's counters live outside and keep running
  wire shut_active = (state_r == `TRC_ST_STOP); // [R14]
  assign wake_irq_out = wake_irq_in && !shut_active; // [R13]
  assign wake_rst_out = wake_rst_in && !shut_active; // [R13]

  // ----------------------------------------
  // Event status and interrupt
  // ----------------------------------------
  assign evt[`TRC_EVT_SHUTDOWN] = (state_r == `TRC_ST_RUN) && (state_nxt == `TRC_ST_STOP);
  assign evt[`TRC_EVT_RESTART] = (state_r == `TRC_ST_STOP) && (state_nxt == `TRC_ST_RESTART);
  assign evt[`TRC_EVT_ARM] = rearm_rise && !armed_r;
  assign evt[`TRC_EVT_DISARM] = recov_rise && !rearm_rise && armed_r;

  always @(posedge clk) begin
    if (rst) begin
      stat_r <= 4'h0;
      mask_r <= 4'h0;
    end else if (ce) begin
      // New events win over a write-one clear in the same cycle
      stat_r <= (stat_r & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | evt;
      if (wr_mask) begin
        mask_r <= reg_wdata[3:0];
      end
    end
  end

  assign irq = |(stat_r & mask_r);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `TRC_ADDR_OPT1: begin
            reg_rdata[`TRC_BIT_ENABLE] <= enable_r;
            reg_rdata[`TRC_BIT_HSEL] <= hsel_r;
          end
          `TRC_ADDR_TEST: begin
            reg_rdata[`TRC_BIT_ARMED] <= armed_r; // [R8]
          end
          `TRC_ADDR_IRQ_STAT: begin
            reg_rdata <= {4'h0, stat_r};
          end
          `TRC_ADDR_IRQ_MASK: begin
            reg_rdata <= {4'h0, mask_r};
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule

// *** trc_defines.vh ***
// Constants for the thermal restart control block
`ifndef TRC_DEFINES_VH
`define TRC_DEFINES_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define TRC_ADDR_W 16
`define TRC_ADDR_OPT1 16'h1802
`define TRC_ADDR_TEST 16'h180f
`define TRC_ADDR_IRQ_STAT 16'h1810
`define TRC_ADDR_IRQ_MASK 16'h1811

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TRC_BIT_ENABLE 3
`define TRC_BIT_HSEL 2
`define TRC_BIT_ARMED 0
`define TRC_NUM_EVT 4
`define TRC_EVT_SHUTDOWN 0
`define TRC_EVT_RESTART 1
`define TRC_EVT_ARM 2
`define TRC_EVT_DISARM 3

// ----------------------------------------
// Reset values and vector
// ----------------------------------------
`define TRC_ARMED_RST 1'b1
`define TRC_RST_VECTOR 16'hdffe
`define TRC_RST_PULSE_CYC 4'h8

// ----------------------------------------
// Sequencer states
// ----------------------------------------
`define TRC_ST_RUN 2'h0
`define TRC_ST_STOP 2'h1
`define TRC_ST_RESTART 2'h2

`endif

// *** trc_sync3.v ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module trc_sync3 #(
  parameter W = 4
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] d_in,
  output reg [W-1:0] q_out
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          q_out[i] <= 1'b0;
        end else if (ce) begin
          s1_r[i] <= d_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          // Accept a change only once stages two and three agree
          if (s2_r[i] == s3_r[i]) begin
            q_out[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule

// *** trc_thermal_restart_monitor.sv ***
// Port assertions for the thermal restart block
`timescale 1ns/10ps
module trc_thermal_restart_monitor (
  input wire clk,
  input wire rst,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire temp_low_shutdown,
  input wire temp_high_shutdown,
  input wire temp_recovery_cross,
  input wire wake_irq_in,
  input wire wake_rst_in,
  input wire wake_irq_out,
  input wire wake_rst_out,
  input wire stop_req,
  input wire core_rst_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_wake_irq_gate: assert property (wake_irq_out == (wake_irq_in & ~stop_req))
    else $error("wake irq gate");
  chk_wake_rst_gate: assert property (wake_rst_out == (wake_rst_in & ~stop_req))
    else $error("wake reset gate");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_pulse_len: assert property ($rose(core_rst_req) |->
    core_rst_req [*8] ##1 core_rst_req ##1 !core_rst_req)
    else $error("restart pulse length");
  chk_restart_from_stop: assert property ($rose(core_rst_req) |-> $past(stop_req))
    else $error("restart outside stop");
  chk_restart_ends_stop: assert property ($rose(core_rst_req) |-> ##[0:2] !stop_req)
    else $error("stop held after restart");
  chk_stop_cause: assert property ($rose(stop_req) |->
    $past(temp_low_shutdown, 3) || $past(temp_high_shutdown, 3))
    else $error("stop without threshold");
  chk_restart_cause: assert property ($rose(core_rst_req) |-> $past(temp_recovery_cross, 3))
    else $error("restart without recovery");
endmodule

bind trc_thermal_restart trc_thermal_restart_monitor u_mon (.clk, .rst, .reg_rd, .reg_rdata,
  .temp_low_shutdown, .temp_high_shutdown, .temp_recovery_cross, .wake_irq_in, .wake_rst_in,
  .wake_irq_out, .wake_rst_out, .stop_req, .core_rst_req);

// *** trc_core_model.sv ***
// Core reset model: counts restart pulses from the block
`timescale 1ns/10ps
module trc_core_model (
  input wire clk,
  input wire rst,
  input wire core_rst_req,
  output reg [7:0] restarts
);
  reg seen_r;
  always @(posedge clk) begin
    seen_r <= core_rst_req;
    if (rst)
      restarts <= 8'h00;
    else if (core_rst_req && !seen_r)
      restarts <= restarts + 8'h01;
  end
endmodule

// *** testbench.sv ***
// Self-checking bench for the thermal restart block
`timescale 1ns/10ps
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic temp_low_shutdown = 1'b0;
  logic temp_high_shutdown = 1'b0;
  logic temp_rearm_cross = 1'b0;
  logic temp_recovery_cross = 1'b0;
  logic wake_irq_in = 1'b0;
  logic wake_rst_in = 1'b0;
  wire [7:0] reg_rdata;
  wire [7:0] restarts;
  wire [15:0] rst_vector;
  wire wake_irq_out, wake_rst_out, stop_req, core_rst_req, irq;
  int num_errors = 0;
  int compares = 0;
  int n;
  always #50 clk = ~clk;
  trc_thermal_restart u_trc_thermal_restart (.clk, .rst, .ce(1'b1), .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .temp_low_shutdown, .temp_high_shutdown, .temp_rearm_cross,
    .temp_recovery_cross, .wake_irq_in, .wake_rst_in, .wake_irq_out, .wake_rst_out, .stop_req,
    .core_rst_req, .rst_vector, .irq);
  trc_core_model u_trc_core_model (.clk, .rst, .core_rst_req, .restarts);
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rdck(input logic [15:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e, nm);
  endtask
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task t_defaults;
    rdck(16'h180f, 8'h01, "armed");
    rdck(16'h1802, 8'h00, "option");
    rdck(16'h1234, 8'h00, "unmapped");
    chk(rst_vector, 16'hdffe, "vector");
  endtask
  task t_arming;
    @(posedge clk);
    temp_recovery_cross <= 1'b1;
    tick(8);
    rdck(16'h180f, 8'h00, "disarmed");
    wr(16'h1802, 8'h0c);
    rdck(16'h1802, 8'h04, "locked");
    @(posedge clk);
    temp_recovery_cross <= 1'b0;
    temp_rearm_cross <= 1'b1;
    tick(8);
    rdck(16'h180f, 8'h01, "rearmed");
    rdck(16'h1810, 8'h0c, "events");
    chk(irq, 1'b0, "masked");
    wr(16'h1811, 8'h0f);
    tick(1);
    chk(irq, 1'b1, "irq");
    wr(16'h1810, 8'h0c);
    tick(1);
    chk(irq, 1'b0, "irq clear");
  endtask
  task t_low;
    wr(16'h1802, 8'h08);
    rdck(16'h1802, 8'h08, "enable");
    @(posedge clk);
    temp_low_shutdown <= 1'b1;
    wake_irq_in <= 1'b1;
    wake_rst_in <= 1'b1;
    for (n = 0; n < 30 && !stop_req; n++) tick(1);
    chk(stop_req, 1'b1, "low stop");
    chk({wake_irq_out, wake_rst_out}, 2'b00, "gated");
    @(posedge clk);
    temp_low_shutdown <= 1'b0;
    temp_recovery_cross <= 1'b1;
    for (n = 0; n < 30 && !core_rst_req; n++) tick(1);
    for (n = 0; n < 20 && core_rst_req; n++) tick(1);
    chk(n[15:0], 16'h0009, "pulse");
    chk(stop_req, 1'b0, "stop end");
    chk(restarts, 8'h01, "restarts");
    chk({wake_irq_out, wake_rst_out}, 2'b11, "ungated");
    rdck(16'h1810, 8'h0b, "stop events");
    rdck(16'h180f, 8'h00, "disarm");
  endtask
  task t_high;
    @(posedge clk);
    temp_recovery_cross <= 1'b0;
    do_reset;
    wr(16'h1802, 8'h0c);
    rdck(16'h1802, 8'h0c, "high select");
    @(posedge clk);
    temp_low_shutdown <= 1'b1;
    tick(10);
    chk(stop_req, 1'b0, "low ignored");
    @(posedge clk);
    temp_high_shutdown <= 1'b1;
    for (n = 0; n < 30 && !stop_req; n++) tick(1);
    chk(stop_req, 1'b1, "high stop");
    wr(16'h1802, 8'h04);
    tick(2);
    chk(stop_req, 1'b0, "disabled");
  endtask
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    do_reset;
    t_defaults;
    t_arming;
    t_low;
    t_high;
    give_verdict;
  end
  initial begin
    #200000;
    num_errors++;
    give_verdict;
  end
endmodule
